/* File: hdl/dadc_channel.sv */
// One converter channel: restart, conversion timer and output hold
`timescale 1ns/1ns
module dadc_channel import dadc_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control from registers and standby tracker
    input wire dadc_chan_ctl_t ctl,
    input wire logic out_allow,
    // Pin side
    output dadc_pin_t pin
);

    logic [7:0] code_d_r;
    logic conv_d_r;
    logic [CNT_W-1:0] cnt_r;
    logic busy_r;
    logic done_r;
    logic [7:0] result_r;
    logic restart;
    logic conv;

    assign conv = ctl.conv_en && out_allow;
    assign restart = conv && (!conv_d_r || ctl.code != code_d_r); // R11

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            code_d_r <= CODE_RESET;
            conv_d_r <= 1'b0;
        end else begin
            code_d_r <= ctl.code;
            conv_d_r <= conv;
        end
    end

    // Conversion timer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
        end else if (!conv) begin
            busy_r <= 1'b0;
        end else if (restart) begin
            cnt_r <= CONV_LOAD; // R14
            busy_r <= 1'b1;
        end else if (busy_r) begin
            cnt_r <= cnt_r - CNT_W'(1);
            busy_r <= cnt_r != '0;
        end
    end

    // Result hold
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            done_r <= 1'b0;
            result_r <= CODE_RESET;
        end else if (!conv || restart) begin
            done_r <= 1'b0; // R13
        end else if (busy_r && cnt_r == '0) begin
            done_r <= 1'b1;
            result_r <= ctl.code; // R16
        end
    end

    // Pin drive
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pin <= '0;
        end else begin
            pin.drive <= ctl.out_en && out_allow; // R12
            pin.conv <= conv;
            pin.valid <= done_r && ctl.out_en && out_allow; // R7
            pin.level <= result_r;
        end
    end

    result_time_a: assert property (@(posedge clk) disable iff (!reset_n) // R14
        restart |-> ##[1:100] (done_r || !conv || restart))
        else $error("conversion result late");

    result_code_a: assert property (@(posedge clk) disable iff (!reset_n) // R16
        (done_r && $stable(ctl.code) && conv) |-> result_r == ctl.code)
        else $error("result differs from code");

endmodule : dadc_channel

/* File: hdl/dadc_standby.sv */
// Standby mode tracker for the converter control
`timescale 1ns/1ns
module dadc_standby import dadc_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Mode inputs
    input wire logic sw_standby,
    input wire logic hw_standby,
    input wire logic standby_output_enable,
    // Controls
    output logic clear_data,
    output logic clear_stby,
    output logic out_allow
);

    dadc_stby_t state_r;
    dadc_stby_t state_nxt;

    always_comb begin
        state_nxt = ST_RUN;
        if (hw_standby) begin
            state_nxt = ST_HW_STBY;
        end else if (sw_standby) begin
            state_nxt = ST_SW_STBY;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_comb begin
        clear_stby = 1'b0;
        clear_data = 1'b0;
        out_allow = 1'b1;
        unique case (state_nxt)
            ST_RUN: begin
                out_allow = 1'b1;
            end
            ST_SW_STBY: begin
                clear_data = !standby_output_enable; // R2
                out_allow = standby_output_enable; // R10
            end
            ST_HW_STBY: begin
                clear_stby = 1'b1; // R9
                clear_data = 1'b1;
                out_allow = 1'b0;
            end
        endcase
    end

    hw_state_a: assert property (@(posedge clk) disable iff (!reset_n) // R9
        hw_standby |=> state_r == ST_HW_STBY)
        else $error("hardware standby not tracked");

endmodule : dadc_standby

/* File: hdl/dadc_top.sv */
// Register file, bus slave and channel control of the dual converter
//
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ns
module dadc_top import dadc_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Write address channel
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // Write data channel
    input wire logic [AXI_DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // Write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read address channel
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // Read data channel
    output logic [AXI_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Standby modes
    input wire logic sw_standby,
    input wire logic hw_standby,
    // Converter pins
    output dadc_pin_t analog_out_ch0,
    output dadc_pin_t analog_out_ch1
);

    // ************************************************************
    // Address decode
    // ************************************************************
    function automatic dadc_reg_t decode(input logic [AXI_AW-1:0] addr);
        dadc_reg_t sel;
        sel = REG_NONE;
        if (addr[1:0] == 2'h0) begin
            unique case (addr)
                OFS_CODE0: sel = REG_CODE0;
                OFS_CODE1: sel = REG_CODE1;
                OFS_CTRL: sel = REG_CTRL;
                OFS_STBY: sel = REG_STBY;
                default: sel = REG_NONE;
            endcase
        end
        return sel;
    endfunction : decode

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] channel0_code_r;
    logic [7:0] channel1_code_r;
    logic ch1_output_enable_r;
    logic ch0_output_enable_r;
    logic joint_conversion_r;
    logic standby_output_enable_r;
    logic [7:0] converter_control;
    logic [7:0] standby_output_control;

    // Bus state
    logic aw_hold_r;
    logic w_hold_r;
    logic [AXI_AW-1:0] awaddr_r;
    logic [7:0] wdata_r;
    logic wlane_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [AXI_DW-1:0] rdata_r;
    logic [1:0] rresp_r;
    logic wr_en;
    dadc_reg_t wr_sel;
    dadc_reg_t rd_sel;
    logic [7:0] rd_byte;

    // Standby controls
    logic clear_data;
    logic clear_stby;
    logic out_allow;

    // Channel controls
    dadc_chan_ctl_t ctl [2];
    dadc_pin_t pins [2];

    assign converter_control = {ch1_output_enable_r, ch0_output_enable_r,
                                joint_conversion_r, CTRL_RSVD}; // R8
    assign standby_output_control = {STBY_RSVD, standby_output_enable_r}; // R8

    // ************************************************************
    // Write channels
    // ************************************************************
    assign s_axi_awready = !aw_hold_r;
    assign s_axi_wready = !w_hold_r;
    assign wr_en = aw_hold_r && w_hold_r && !bvalid_r;
    assign wr_sel = decode(awaddr_r);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_hold_r <= 1'b0;
            awaddr_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end else if (wr_en) begin
            aw_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            w_hold_r <= 1'b0;
            wdata_r <= '0;
            wlane_r <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata[7:0];
            wlane_r <= s_axi_wstrb[0];
        end else if (wr_en) begin
            w_hold_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_en) begin
            bvalid_r <= 1'b1;
            bresp_r <= (wr_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // ************************************************************
    // Read channels
    // ************************************************************
    assign s_axi_arready = !rvalid_r;
    assign rd_sel = decode(s_axi_araddr);

    always_comb begin
        rd_byte = 8'h00;
        unique case (rd_sel)
            REG_CODE0: rd_byte = channel0_code_r;
            REG_CODE1: rd_byte = channel1_code_r;
            REG_CTRL: rd_byte = converter_control;
            REG_STBY: rd_byte = standby_output_control;
            REG_NONE: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h000000, rd_byte};
            rresp_r <= (rd_sel == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // ************************************************************
    // Standby tracking
    // ************************************************************
    dadc_standby u_standby (
        .clk(clk),
        .reset_n(reset_n),
        .sw_standby(sw_standby),
        .hw_standby(hw_standby),
        .standby_output_enable(standby_output_enable_r),
        .clear_data(clear_data),
        .clear_stby(clear_stby),
        .out_allow(out_allow)
    );

    // ************************************************************
    // Channel code registers
    // ************************************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            channel0_code_r <= CODE_RESET; // R1
        end else if (clear_data) begin
            channel0_code_r <= CODE_RESET; // R1
        end else if (wr_en && wlane_r && wr_sel == REG_CODE0) begin
            channel0_code_r <= wdata_r; // R15
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            channel1_code_r <= CODE_RESET; // R1
        end else if (clear_data) begin
            channel1_code_r <= CODE_RESET; // R1
        end else if (wr_en && wlane_r && wr_sel == REG_CODE1) begin
            channel1_code_r <= wdata_r; // R15
        end
    end

    // ************************************************************
    // Converter control register
    // ************************************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ch1_output_enable_r <= CTRL_RESET[CTRL_OE1_BIT]; // R3
            ch0_output_enable_r <= CTRL_RESET[CTRL_OE0_BIT];
            joint_conversion_r <= CTRL_RESET[CTRL_JOINT_BIT];
        end else if (clear_data) begin
            ch1_output_enable_r <= CTRL_RESET[CTRL_OE1_BIT]; // R3
            ch0_output_enable_r <= CTRL_RESET[CTRL_OE0_BIT];
            joint_conversion_r <= CTRL_RESET[CTRL_JOINT_BIT];
        end else if (wr_en && wlane_r && wr_sel == REG_CTRL) begin
            ch1_output_enable_r <= wdata_r[CTRL_OE1_BIT]; // R4
            ch0_output_enable_r <= wdata_r[CTRL_OE0_BIT]; // R5
            joint_conversion_r <= wdata_r[CTRL_JOINT_BIT];
        end
    end

    // ************************************************************
    // Standby output control register
    // ************************************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            standby_output_enable_r <= STBY_RESET[STBY_STE_BIT]; // R9
        end else if (clear_stby) begin
            standby_output_enable_r <= STBY_RESET[STBY_STE_BIT]; // R9
        end else if (wr_en && wlane_r && wr_sel == REG_STBY) begin
            standby_output_enable_r <= wdata_r[STBY_STE_BIT]; // R10
        end
    end

    // ************************************************************
    // Channels
    // ************************************************************
    always_comb begin
        ctl[0].out_en = ch0_output_enable_r;
        ctl[1].out_en = ch1_output_enable_r;
        ctl[0].conv_en = ch0_output_enable_r
                         || (joint_conversion_r && ch1_output_enable_r); // R6
        ctl[1].conv_en = ch1_output_enable_r
                         || (joint_conversion_r && ch0_output_enable_r); // R6
        ctl[0].code = channel0_code_r; // R16
        ctl[1].code = channel1_code_r; // R16
    end

    for (genvar i = 0; i < 2; i++) begin : g_chan
        dadc_channel u_chan (
            .clk(clk),
            .reset_n(reset_n),
            .ctl(ctl[i]),
            .out_allow(out_allow),
            .pin(pins[i])
        );
    end

    assign analog_out_ch0 = pins[0];
    assign analog_out_ch1 = pins[1];

    // ************************************************************
    // Checks
    // ************************************************************
    code_clear_a: assert property (@(posedge clk) disable iff (!reset_n) // R1
        hw_standby |=> (channel0_code_r == CODE_RESET)
                       && (channel1_code_r == CODE_RESET))
        else $error("code not cleared in standby");

    standby_keep_a: assert property (@(posedge clk) disable iff (!reset_n) // R2
        (sw_standby && !hw_standby && standby_output_enable_r && !wr_en)
        |=> $stable(channel0_code_r) && $stable(converter_control))
        else $error("registers lost in retained standby");

    ctrl_clear_a: assert property (@(posedge clk) disable iff (!reset_n) // R3
        (sw_standby && !hw_standby && !standby_output_enable_r)
        |=> converter_control == CTRL_RESET)
        else $error("control not reloaded on standby");

    ch1_enable_a: assert property (@(posedge clk) disable iff (!reset_n) // R4
        (wr_en && wlane_r && wr_sel == REG_CTRL && !clear_data
         && !sw_standby && !hw_standby)
        ##1 (!sw_standby && !hw_standby)
        |=> analog_out_ch1.drive == $past(wdata_r[CTRL_OE1_BIT], 2))
        else $error("channel 1 drive not following bit 7");

    own_drive_a: assert property (@(posedge clk) disable iff (!reset_n) // R7
        analog_out_ch0.drive |-> $past(ch0_output_enable_r))
        else $error("channel 0 driven without its enable");

    joint_conv_a: assert property (@(posedge clk) disable iff (!reset_n) // R6
        (joint_conversion_r && ch1_output_enable_r && out_allow)
        |=> analog_out_ch0.conv)
        else $error("joint conversion missing on channel 0");

    reserved_read_a: assert property (@(posedge clk) disable iff (!reset_n) // R8
        (s_axi_arvalid && s_axi_arready && rd_sel == REG_CTRL)
        |=> s_axi_rvalid && s_axi_rdata[4:0] == CTRL_RSVD)
        else $error("reserved control bits not read as one");

    stby_reg_a: assert property (@(posedge clk) disable iff (!reset_n) // R9
        (sw_standby && !hw_standby && !wr_en)
        |=> $stable(standby_output_control))
        else $error("standby register changed in software standby");

    stby_out_a: assert property (@(posedge clk) disable iff (!reset_n) // R10
        (sw_standby && !standby_output_enable_r) ##1 sw_standby
        |-> !analog_out_ch0.drive && !analog_out_ch1.drive)
        else $error("output active in standby without enable");

    pin_release_a: assert property (@(posedge clk) disable iff (!reset_n) // R12
        $fell(ch0_output_enable_r) |=> !analog_out_ch0.drive)
        else $error("pin not released after enable cleared");

    result_hold_a: assert property (@(posedge clk) disable iff (!reset_n) // R13
        (analog_out_ch0.valid && $stable(channel0_code_r)
         && channel0_code_r == $past(channel0_code_r, 2)
         && ch0_output_enable_r && out_allow)
        |=> analog_out_ch0.valid && $stable(analog_out_ch0.level))
        else $error("result not held");

    write_store_a: assert property (@(posedge clk) disable iff (!reset_n) // R15
        (wr_en && wlane_r && wr_sel == REG_CODE0 && !clear_data)
        |=> channel0_code_r == $past(wdata_r))
        else $error("code write not stored at response edge");

    restart_a: assert property (@(posedge clk) disable iff (!reset_n) // R11
        (ch0_output_enable_r && out_allow
         && channel0_code_r != $past(channel0_code_r))
        |-> ##2 !analog_out_ch0.valid)
        else $error("code change did not restart conversion");

endmodule : dadc_top

/* File: include/dadc_pkg.sv */
// Package of constants and types for the dual channel converter control
// Summary of operation
// [R1] Channel codes 8 bit RW, clear to 00
// [R2] Standby enable keeps registers in software standby
// [R3] Control register loads 1F on reset, standby
// [R4] Bit 7 enables channel 1 conversion, output
// [R5] Bit 6 enables channel 0 conversion, output
// [R6] Joint bit: either enable converts both channels
// [R7] Pin driven only by own output enable
// [R8] Reserved bits ignore writes, read as one
// [R9] Standby register loads FE, survives software standby
// [R10] Bit 0 keeps outputs active in software standby
// [R11] Code change restarts conversion at once
// [R12] Enable set drives pin, cleared releases it
// [R13] Output holds result until code or enable changes
// [R14] Result appears within 10 us of start
// [R15] Write stores at edge, reaches converter next cycle
// [R16] Code passes unchanged to conversion circuit
package dadc_pkg;

    // ************************************************************
    // Bus and register map
    // ************************************************************
    localparam int AXI_AW = 8;
    localparam int AXI_DW = 32;
    localparam logic [AXI_AW-1:0] OFS_CODE0 = 8'h00;
    localparam logic [AXI_AW-1:0] OFS_CODE1 = 8'h04;
    localparam logic [AXI_AW-1:0] OFS_CTRL = 8'h08;
    localparam logic [AXI_AW-1:0] OFS_STBY = 8'h0C;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int CTRL_OE1_BIT = 7;
    localparam int CTRL_OE0_BIT = 6;
    localparam int CTRL_JOINT_BIT = 5;
    localparam int STBY_STE_BIT = 0;
    localparam logic [7:0] CODE_RESET = 8'h00;
    localparam logic [7:0] CTRL_RESET = 8'h1F;
    localparam logic [7:0] STBY_RESET = 8'hFE;
    localparam logic [4:0] CTRL_RSVD = 5'h1F;
    localparam logic [6:0] STBY_RSVD = 7'h7F;

    // ************************************************************
    // Conversion timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int CONV_TIME_NS = 10000;
    localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int CNT_W = $clog2(CONV_CYCLES + 1);
    // Restart, done and pin flops take the other three cycles
    localparam logic [CNT_W-1:0] CONV_LOAD = CNT_W'(CONV_CYCLES - 3);

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        REG_CODE0, REG_CODE1, REG_CTRL, REG_STBY, REG_NONE
    } dadc_reg_t;

    typedef enum logic [1:0] {
        ST_RUN, ST_SW_STBY, ST_HW_STBY
    } dadc_stby_t;

    typedef struct packed {
        logic conv_en;
        logic out_en;
        logic [7:0] code;
    } dadc_chan_ctl_t;

    typedef struct packed {
        logic drive;
        logic conv;
        logic valid;
        logic [7:0] level;
    } dadc_pin_t;

endpackage : dadc_pkg

/* File: testbench/tb_top.sv */
// Self-checking bench for the dual converter control block
`timescale 1ns/1ns
module tb_top;
import dadc_pkg::*;
logic clk = 1'b0;
logic reset_n = 1'b0;
logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
logic [AXI_DW-1:0] wdata = '0, rdata;
logic [3:0] wstrb = 4'h0;
logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
logic awready, wready, bvalid, arready, rvalid;
logic [1:0] bresp, rresp;
logic sw_standby = 0, hw_standby = 0;
dadc_pin_t pin0, pin1;
int errors = 0;
int cmp_count = 0;
int cycles = 0;
always #50 clk = ~clk;
dadc_top dut (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sw_standby(sw_standby), .hw_standby(hw_standby),
    .analog_out_ch0(pin0), .analog_out_ch1(pin1));
// ************************************************************
// Checking and closing
// ************************************************************
task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
        errors++;
        $display("BAD %s expected %h seen %h", n, exp, seen);
    end
endtask : chk
task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
        $display("[ PASS ]");
    end else begin
        $display("[ FAIL ]");
    end
    $finish;
endtask : wrap_up
always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
        errors++;
        wrap_up();
    end
end
// ************************************************************
// Bus tasks
// ************************************************************
task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1;
    wdata <= d;
    wstrb <= 4'hF;
    wvalid <= 1;
    bready <= 1;
    while (!done) begin
        @(posedge clk);
        if (awvalid && awready) awvalid <= 0;
        if (wvalid && wready) wvalid <= 0;
        if (bvalid) begin
            done = 1;
            bready <= 0;
            chk("bresp", {30'h0, bresp}, {30'h0, er});
        end
    end
endtask : wr
task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic done;
    done = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!done) begin
        @(posedge clk);
        if (arvalid && arready) arvalid <= 0;
        if (rvalid) begin
            done = 1;
            rready <= 0;
            chk("rdata", rdata, e);
            chk("rresp", {30'h0, rresp}, {30'h0, er});
        end
    end
endtask : rd
task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
endtask : tick
task automatic pchk(input dadc_pin_t p, input logic dr, input logic cv, input logic vl);
    chk("drive", {31'h0, p.drive}, {31'h0, dr});
    chk("conv", {31'h0, p.conv}, {31'h0, cv});
    chk("valid", {31'h0, p.valid}, {31'h0, vl});
endtask : pchk
// ************************************************************
// Tests
// ************************************************************
initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1;
    rd(OFS_CODE0, 32'h00, RESP_OKAY);
    rd(OFS_CODE1, 32'h00, RESP_OKAY);
    rd(OFS_CTRL, 32'h1F, RESP_OKAY);
    rd(OFS_STBY, 32'hFE, RESP_OKAY);
    rd(8'h10, 32'h00, RESP_SLVERR);
    wr(8'h10, 32'hFF, RESP_SLVERR);
    $display("reset values done");
    wr(OFS_CODE0, 32'hA5, RESP_OKAY);
    wr(OFS_CODE1, 32'h3C, RESP_OKAY);
    rd(OFS_CODE0, 32'hA5, RESP_OKAY);
    rd(OFS_CODE1, 32'h3C, RESP_OKAY);
    wr(OFS_CTRL, 32'h00, RESP_OKAY);
    rd(OFS_CTRL, 32'h1F, RESP_OKAY);
    wr(OFS_STBY, 32'h00, RESP_OKAY);
    rd(OFS_STBY, 32'hFE, RESP_OKAY);
    $display("register access done");
    wr(OFS_CTRL, 32'h40, RESP_OKAY);
    tick(1);
    pchk(pin0, 1, 1, 0);
    pchk(pin1, 0, 0, 0);
    tick(97);
    pchk(pin0, 1, 1, 0);
    tick(1);
    pchk(pin0, 1, 1, 1);
    chk("level0", {24'h0, pin0.level}, 32'hA5);
    tick(20);
    pchk(pin0, 1, 1, 1);
    wr(OFS_CODE0, 32'h5A, RESP_OKAY);
    tick(1);
    chk("valid0", {31'h0, pin0.valid}, 32'h0);
    tick(105);
    chk("level0", {24'h0, pin0.level}, 32'h5A);
    $display("conversion done");
    wr(OFS_CTRL, 32'h60, RESP_OKAY);
    tick(1);
    pchk(pin1, 0, 1, 0);
    wr(OFS_CTRL, 32'h20, RESP_OKAY);
    tick(1);
    pchk(pin0, 0, 0, 0);
    pchk(pin1, 0, 0, 0);
    wr(OFS_CTRL, 32'h80, RESP_OKAY);
    tick(1);
    pchk(pin1, 1, 1, 0);
    pchk(pin0, 0, 0, 0);
    tick(99);
    pchk(pin1, 1, 1, 1);
    chk("level1", {24'h0, pin1.level}, 32'h3C);
    wr(OFS_CTRL, 32'hA0, RESP_OKAY);
    tick(1);
    pchk(pin0, 0, 1, 0);
    $display("joint conversion done");
    wr(OFS_CTRL, 32'h40, RESP_OKAY);
    @(posedge clk);
    sw_standby <= 1;
    tick(3);
    chk("drive0", {31'h0, pin0.drive}, 32'h0);
    rd(OFS_CODE0, 32'h00, RESP_OKAY);
    rd(OFS_CTRL, 32'h1F, RESP_OKAY);
    @(posedge clk);
    sw_standby <= 0;
    wr(OFS_CODE0, 32'h77, RESP_OKAY);
    wr(OFS_CTRL, 32'hC0, RESP_OKAY);
    wr(OFS_STBY, 32'h01, RESP_OKAY);
    @(posedge clk);
    sw_standby <= 1;
    tick(3);
    chk("drive0", {31'h0, pin0.drive}, 32'h1);
    rd(OFS_CODE0, 32'h77, RESP_OKAY);
    rd(OFS_CTRL, 32'hDF, RESP_OKAY);
    rd(OFS_STBY, 32'hFF, RESP_OKAY);
    @(posedge clk);
    sw_standby <= 0;
    hw_standby <= 1;
    repeat (2) @(posedge clk);
    hw_standby <= 0;
    rd(OFS_STBY, 32'hFE, RESP_OKAY);
    rd(OFS_CODE0, 32'h00, RESP_OKAY);
    rd(OFS_CTRL, 32'h1F, RESP_OKAY);
    $display("standby done");
    wrap_up();
end
endmodule : tb_top
